// File: hdl/atli_pkg.sv
// Constants, field layout and carriers for the async terminal line interface
package atli_pkg;

	// Clock and timing
	localparam int unsigned ATLI_CLK_HZ     = 200_000_000;
	localparam int unsigned ATLI_PERIOD_PS  = 5_000;
	localparam int unsigned ATLI_DISC_NS    = 700;
	localparam int unsigned ATLI_HOLD_NS    = 750;
	localparam int unsigned ATLI_CLR_NS     = 2_000;
	// Pulse length exact, hold rounds up, clear stretch rounds up
	localparam int unsigned ATLI_DISC_CYC   = (ATLI_DISC_NS * 1000)
		/ ATLI_PERIOD_PS;
	localparam int unsigned ATLI_HOLD_CYC   = (ATLI_HOLD_NS * 1000
		+ ATLI_PERIOD_PS - 1) / ATLI_PERIOD_PS;
	localparam int unsigned ATLI_CLR_CYC    = (ATLI_CLR_NS * 1000
		+ ATLI_PERIOD_PS - 1) / ATLI_PERIOD_PS;

	// Output word fields
	localparam int ATLI_B_UPPER = 15;
	localparam int ATLI_B_RXOFF = 14;
	localparam int ATLI_B_RXON  = 13;
	localparam int ATLI_B_WIDE  = 12;
	localparam int ATLI_B_SETI  = 11;
	localparam int ATLI_B_SETO  = 10;
	localparam int ATLI_B_DISC  = 9;
	localparam int ATLI_B_LOWER = 8;
	localparam int ATLI_B_OPAR  = 7;
	localparam int ATLI_B_IPAR  = 6;
	localparam int ATLI_B_EVEN  = 5;
	localparam int ATLI_B_OSEL  = 4;
	localparam int ATLI_B_PBIT  = 7;

	// Status field position (input flag, output flag, break, lost)
	localparam int ATLI_ST_LSB  = 8;

	// Speed codes
	localparam logic [3:0] ATLI_SPD_KEEP  = 4'h0;
	localparam logic [3:0] ATLI_SPD_MAX   = 4'h9;
	localparam logic [3:0] ATLI_SPD_RESET = 4'h9;

	// Serial framing
	localparam logic [3:0] ATLI_OVS_LAST  = 4'hF;
	localparam logic [3:0] ATLI_OVS_MID   = 4'h7;
	localparam logic [3:0] ATLI_DATA_LAST = 4'h7;
	localparam logic [3:0] ATLI_TX_BITS   = 4'hA;
	localparam int unsigned ATLI_OVS      = 16;

	typedef struct packed {
		logic        wide;
		logic [15:0] word;
	} atli_entry_type;

	typedef struct packed {
		logic iflag;
		logic oflag;
		logic brk;
		logic lost;
	} atli_status_type;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} atli_rx_state_type;

	function automatic int unsigned atli_rate(input logic [3:0] code);
		case (code)
			4'h1:    return 110;
			4'h2:    return 150;
			4'h3:    return 300;
			4'h4:    return 600;
			4'h5:    return 1200;
			4'h6:    return 1800;
			4'h7:    return 2400;
			4'h8:    return 4800;
			default: return 9600;
		endcase
	endfunction

	// Counter reload for a 16x sample tick: core clock cycles per tick minus one
	function automatic logic [23:0] atli_div(input logic [3:0] code,
		input int unsigned hz);
		return 24'((hz / (ATLI_OVS * atli_rate(code))) - 1);
	endfunction

endpackage

// File: hdl/atli_line_iface.sv
// Async terminal line interface: control, status, transmitter, receiver
`timescale 1ns/1ps
module atli_line_iface
	import atli_pkg::*;
#(
	parameter int unsigned core_hz = ATLI_CLK_HZ
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        power_on_preset_pulse,
	input  wire logic        clear_control_instruction,
	input  wire logic        output_word_to_card,
	input  wire logic [15:0] out_word,
	input  wire logic        load_word_from_card,
	input  wire logic        rd_sel_data,
	input  wire logic        rxd_pin,
	input  wire logic        carrier_pin,
	input  wire logic        modem_pin,
	output logic             out_ready,
	output logic [15:0]      rd_word,
	output logic             card_flag,
	output logic             txd_pin,
	output logic             term_ready_pin
);

	// Control function decode
	logic is_ctrl, ctrl_up, ctrl_lo, ctrl_seti, ctrl_seto, ctrl_disc;
	logic wide_ff, rx_en_ff, opar_ff, ipar_ff, even_ff;
	logic [3:0] out_spd_ff, in_spd_ff;

	assign is_ctrl = output_word_to_card && !wide_ff
		&& (out_word[ATLI_B_UPPER] || out_word[ATLI_B_LOWER]);
	assign ctrl_up   = is_ctrl && out_word[ATLI_B_UPPER];
	assign ctrl_lo   = is_ctrl && out_word[ATLI_B_LOWER];
	assign ctrl_seti = ctrl_up && out_word[ATLI_B_SETI];
	assign ctrl_seto = ctrl_up && out_word[ATLI_B_SETO];
	assign ctrl_disc = ctrl_up && out_word[ATLI_B_DISC];

	// Mode leaves wide only through reset, clear-control or preset
	always_ff @(posedge core_clk) begin
		if (srst || power_on_preset_pulse || clear_control_instruction)
			wide_ff <= 1'b0;
		else if (ctrl_up && out_word[ATLI_B_WIDE])
			wide_ff <= 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			rx_en_ff <= 1'b1;
		else if (ctrl_up && out_word[ATLI_B_RXOFF])
			rx_en_ff <= 1'b0;
		else if (ctrl_up && out_word[ATLI_B_RXON])
			rx_en_ff <= 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			opar_ff    <= 1'b0;
			ipar_ff    <= 1'b0;
			even_ff    <= 1'b0;
			out_spd_ff <= ATLI_SPD_RESET;
			in_spd_ff  <= ATLI_SPD_RESET;
		end else if (ctrl_lo) begin
			opar_ff <= out_word[ATLI_B_OPAR];
			ipar_ff <= out_word[ATLI_B_IPAR];
			even_ff <= out_word[ATLI_B_EVEN];
			// Unknown codes above the table are ignored like a keep code
			if (out_word[3:0] != ATLI_SPD_KEEP
				&& out_word[3:0] <= ATLI_SPD_MAX) begin
				if (out_word[ATLI_B_OSEL])
					out_spd_ff <= out_word[3:0];
				else
					in_spd_ff <= out_word[3:0];
			end
		end
	end

	// Disconnect pulse on terminal ready
	logic [7:0] disc_cnt_ff;
	always_ff @(posedge core_clk) begin
		if (srst)
			disc_cnt_ff <= 8'h00;
		else if (ctrl_disc)
			disc_cnt_ff <= 8'(ATLI_DISC_CYC);
		else if (disc_cnt_ff != 8'h00)
			disc_cnt_ff <= disc_cnt_ff - 8'h01;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			term_ready_pin <= 1'b1;
		else
			term_ready_pin <= !(ctrl_disc
				|| disc_cnt_ff > 8'h01);
	end

	// Clear stretch for transmitter and receiver after preset
	logic [8:0] clr_cnt_ff;
	logic       clr_act;
	always_ff @(posedge core_clk) begin
		if (srst || power_on_preset_pulse)
			clr_cnt_ff <= 9'(ATLI_CLR_CYC);
		else if (clr_act)
			clr_cnt_ff <= clr_cnt_ff - 9'h001;
	end
	assign clr_act = clr_cnt_ff != 9'h000;

	// Two-entry buffer between the computer and the auxiliary buffer
	atli_entry_type fifo_ff [2];
	logic       wr_ptr_ff, rd_ptr_ff, push, pop, aux_empty;
	logic [1:0] cnt_ff, nxt_cnt;
	assign push = output_word_to_card && !is_ctrl && cnt_ff != 2'h2;
	assign pop  = cnt_ff != 2'h0 && aux_empty && !clr_act;
	always_comb begin
		nxt_cnt = cnt_ff;
		if (push && !pop)
			nxt_cnt = cnt_ff + 2'h1;
		else if (pop && !push)
			nxt_cnt = cnt_ff - 2'h1;
	end

	always_ff @(posedge core_clk) begin
		if (srst || power_on_preset_pulse) begin
			cnt_ff    <= 2'h0;
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			out_ready <= 1'b1;
		end else begin
			cnt_ff    <= nxt_cnt;
			out_ready <= nxt_cnt != 2'h2;
			if (push)
				wr_ptr_ff <= !wr_ptr_ff;
			if (pop)
				rd_ptr_ff <= !rd_ptr_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			fifo_ff[wr_ptr_ff].wide <= wide_ff;
			fifo_ff[wr_ptr_ff].word <= out_word;
		end
	end

	// Auxiliary buffer and transmitter holding buffer
	logic [15:0] aux_ff;
	logic        aux_hi_ff, aux_lo_ff, hold_full_ff, xfer_hi, xfer_lo;
	logic [7:0]  hold_ff;
	logic [7:0]  hold_age_ff;
	logic        tx_load, tx_busy_ff;
	assign aux_empty = !aux_hi_ff && !aux_lo_ff;
	assign xfer_hi = aux_hi_ff && !hold_full_ff && !clr_act;
	assign xfer_lo = !aux_hi_ff && aux_lo_ff && !hold_full_ff
		&& !clr_act;
	assign tx_load = hold_full_ff && !tx_busy_ff && !clr_act
		&& hold_age_ff >= 8'(ATLI_HOLD_CYC);

	always_ff @(posedge core_clk) begin
		if (srst || power_on_preset_pulse) begin
			aux_hi_ff <= 1'b0;
			aux_lo_ff <= 1'b0;
		end else if (pop) begin
			// Narrow entries carry only data bits 0-7
			aux_ff    <= fifo_ff[rd_ptr_ff].word;
			aux_hi_ff <= fifo_ff[rd_ptr_ff].wide;
			aux_lo_ff <= 1'b1;
		end else if (xfer_hi) begin
			aux_hi_ff <= 1'b0;
		end else if (xfer_lo) begin
			aux_lo_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || power_on_preset_pulse) begin
			hold_full_ff <= 1'b0;
			hold_age_ff  <= 8'h00;
		end else if (xfer_hi || xfer_lo) begin
			hold_ff      <= xfer_hi ? aux_ff[15:8] : aux_ff[7:0];
			hold_full_ff <= 1'b1;
			hold_age_ff  <= 8'h00;
		end else if (tx_load) begin
			hold_full_ff <= 1'b0;
		end else if (hold_full_ff && hold_age_ff != 8'hFF) begin
			hold_age_ff <= hold_age_ff + 8'h01;
		end
	end

	// Transmitter: 16x tick, start, 8 data, stop
	logic [23:0] tx_div_ff;
	logic [3:0]  tx_sub_ff, tx_bit_ff;
	logic [9:0]  tx_shift_ff;
	logic        tx_tick;
	logic [7:0]  tx_char;
	assign tx_tick = tx_div_ff == 24'h000000;
	always_comb begin
		tx_char = hold_ff;
		if (opar_ff)
			tx_char[ATLI_B_PBIT] = even_ff ? ^hold_ff[6:0]
				: ~^hold_ff[6:0];
	end

	always_ff @(posedge core_clk) begin
		if (srst || clr_act || !tx_busy_ff || tx_tick)
			tx_div_ff <= atli_div(out_spd_ff, core_hz);
		else
			tx_div_ff <= tx_div_ff - 24'h000001;
	end

	always_ff @(posedge core_clk) begin
		if (srst || clr_act) begin
			tx_busy_ff  <= 1'b0;
			tx_shift_ff <= 10'h3FF;
			tx_sub_ff   <= 4'h0;
			tx_bit_ff   <= 4'h0;
		end else if (tx_load) begin
			tx_busy_ff  <= 1'b1;
			tx_shift_ff <= {1'b1, tx_char, 1'b0};
			tx_sub_ff   <= 4'h0;
			tx_bit_ff   <= 4'h0;
		end else if (tx_busy_ff && tx_tick) begin
			tx_sub_ff <= tx_sub_ff + 4'h1;
			if (tx_sub_ff == ATLI_OVS_LAST) begin
				tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
				tx_bit_ff   <= tx_bit_ff + 4'h1;
				if (tx_bit_ff == ATLI_TX_BITS - 4'h1)
					tx_busy_ff <= 1'b0;
			end
		end
	end
	assign txd_pin = tx_shift_ff[0];

	// Pin synchronisers
	logic rxd_s1_ff, rxd_s2_ff, cd_s1_ff, cd_s2_ff, md_s1_ff, md_s2_ff;
	always_ff @(posedge core_clk) begin
		rxd_s1_ff <= rxd_pin;
		rxd_s2_ff <= rxd_s1_ff;
		cd_s1_ff  <= carrier_pin;
		cd_s2_ff  <= cd_s1_ff;
		md_s1_ff  <= modem_pin;
		md_s2_ff  <= md_s1_ff;
	end

	// Receiver
	atli_rx_state_type rx_state_ff;
	logic [23:0] rx_div_ff;
	logic [3:0]  rx_sub_ff, rx_bit_ff;
	logic [7:0]  rx_shift_ff, rx_buf_ff, rx_char;
	logic        rx_clr, rx_gate, rx_tick, rx_full_ff, rx_done;
	logic        stop_ok, stop_bad, data_rd;
	assign rx_clr  = clr_act || !rx_en_ff;
	assign rx_gate = rx_state_ff != RX_IDLE || rx_full_ff;
	assign rx_tick = rx_gate && rx_div_ff == 24'h000000;
	assign rx_done = rx_state_ff == RX_STOP && rx_tick
		&& rx_sub_ff == ATLI_OVS_LAST;
	assign stop_ok  = rx_done && rxd_s2_ff;
	assign stop_bad = rx_done && !rxd_s2_ff;
	assign data_rd  = load_word_from_card && rd_sel_data;
	always_comb begin
		rx_char = rx_shift_ff;
		if (ipar_ff && (^rx_shift_ff[6:0] ^ rx_shift_ff[ATLI_B_PBIT]
			^ !even_ff))
			rx_char[ATLI_B_PBIT] = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (srst || rx_clr || !rx_gate || rx_tick
			|| rx_state_ff == RX_IDLE)
			rx_div_ff <= atli_div(in_spd_ff, core_hz);
		else
			rx_div_ff <= rx_div_ff - 24'h000001;
	end

	always_ff @(posedge core_clk) begin
		if (srst || rx_clr) begin
			rx_state_ff <= RX_IDLE;
			rx_sub_ff   <= 4'h0;
			rx_bit_ff   <= 4'h0;
		end else begin
			if (rx_tick)
				rx_sub_ff <= rx_sub_ff + 4'h1;
			case (rx_state_ff)
				RX_IDLE: begin
					rx_sub_ff <= 4'h0;
					if (!rxd_s2_ff)
						rx_state_ff <= RX_START;
				end
				RX_START: begin
					if (rx_tick && rx_sub_ff == ATLI_OVS_MID) begin
						rx_sub_ff   <= 4'h0;
						rx_bit_ff   <= 4'h0;
						rx_state_ff <= rxd_s2_ff ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_tick && rx_sub_ff == ATLI_OVS_LAST) begin
						rx_shift_ff <= {rxd_s2_ff, rx_shift_ff[7:1]};
						rx_bit_ff   <= rx_bit_ff + 4'h1;
						if (rx_bit_ff == ATLI_DATA_LAST)
							rx_state_ff <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_done)
						rx_state_ff <= RX_IDLE;
				end
				default: rx_state_ff <= RX_IDLE;
			endcase
		end
	end

	// Input buffer: load on completion, data read empties it
	always_ff @(posedge core_clk) begin
		if (srst || rx_clr)
			rx_full_ff <= 1'b0;
		else if (rx_done)
			rx_full_ff <= 1'b1;
		else if (data_rd)
			rx_full_ff <= 1'b0;
		if (rx_done)
			rx_buf_ff <= rx_char;
	end

	// Break and carrier
	logic cd_prev_ff, cd_drop, cd_back, brk_set, brk_clr;
	always_ff @(posedge core_clk) begin
		cd_prev_ff <= cd_s2_ff;
	end
	assign cd_drop = md_s2_ff && cd_prev_ff && !cd_s2_ff;
	assign cd_back = md_s2_ff && !cd_prev_ff && cd_s2_ff;
	assign brk_set = stop_bad || cd_drop;

	// Status flags: every set beats a read clear
	atli_status_type st_ff;
	logic iset, oset, rd_clr;
	assign brk_clr = cd_back
		|| (!md_s2_ff && stop_ok && st_ff.brk);
	assign rd_clr = load_word_from_card;
	assign iset = ctrl_seti || rx_done || brk_set || brk_clr;
	assign oset = ctrl_seto || xfer_lo;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_ff <= '0;
		end else begin
			if (iset)
				st_ff.iflag <= 1'b1;
			else if (rd_clr)
				st_ff.iflag <= 1'b0;
			if (oset)
				st_ff.oflag <= 1'b1;
			else if (rd_clr)
				st_ff.oflag <= 1'b0;
			if (rx_done && rx_full_ff && !data_rd)
				st_ff.lost <= 1'b1;
			else if (rd_clr)
				st_ff.lost <= 1'b0;
			if (brk_set)
				st_ff.brk <= 1'b1;
			else if (brk_clr)
				st_ff.brk <= 1'b0;
		end
	end

	// Read word and flag output
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_word   <= 16'h0000;
			card_flag <= 1'b0;
		end else begin
			card_flag <= st_ff.iflag || st_ff.oflag;
			if (load_word_from_card)
				rd_word <= rd_sel_data ? {8'h00, rx_buf_ff}
					: 16'(st_ff) << ATLI_ST_LSB;
		end
	end

	// Checks
	localparam int DISC_LEN = ATLI_DISC_CYC;
	logic [7:0] low_len_ff;
	always_ff @(posedge core_clk) begin
		if (srst || term_ready_pin)
			low_len_ff <= 8'h00;
		else
			low_len_ff <= low_len_ff + 8'h01;
	end

	sequence s_disc_go;
		ctrl_disc ##1 !term_ready_pin;
	endsequence
	property p_disc_start;
		@(posedge core_clk) disable iff (srst)
		ctrl_disc |-> s_disc_go;
	endproperty
	a_disc_start: assert property (p_disc_start)
		else $error("disconnect pulse did not start");

	property p_disc_len;
		@(posedge core_clk) disable iff (srst)
		$rose(term_ready_pin) && !$past(srst)
			|-> $past(low_len_ff) == 8'(DISC_LEN - 1);
	endproperty
	a_disc_len: assert property (p_disc_len)
		else $error("disconnect pulse has wrong length");

	// Counted apart from the load gate so a wrong threshold shows up
	logic [7:0] hold_stab_ff;
	always_ff @(posedge core_clk) begin
		if (srst || xfer_hi || xfer_lo)
			hold_stab_ff <= 8'h00;
		else if (hold_stab_ff != 8'hFF)
			hold_stab_ff <= hold_stab_ff + 8'h01;
	end

	property p_hold_min;
		@(posedge core_clk) disable iff (srst)
		tx_load |-> hold_stab_ff >= 8'(ATLI_HOLD_CYC);
	endproperty
	a_hold_min: assert property (p_hold_min)
		else $error("holding data left before minimum time");

	sequence s_hi_then_lo;
		xfer_hi ##1 aux_lo_ff && !aux_hi_ff;
	endsequence
	property p_wide_order;
		@(posedge core_clk) disable iff (srst || power_on_preset_pulse)
		xfer_hi |-> s_hi_then_lo;
	endproperty
	a_wide_order: assert property (p_wide_order)
		else $error("low byte not kept after high byte");

	property p_oflag_cause;
		@(posedge core_clk) disable iff (srst)
		$rose(st_ff.oflag) |-> $past(xfer_lo) || $past(ctrl_seto);
	endproperty
	a_oflag_cause: assert property (p_oflag_cause)
		else $error("output flag set without cause");

	property p_clc_mode;
		@(posedge core_clk) disable iff (srst)
		clear_control_instruction |=> !wide_ff;
	endproperty
	a_clc_mode: assert property (p_clc_mode)
		else $error("clear control left wide mode");

	property p_set_wins;
		@(posedge core_clk) disable iff (srst)
		iset && rd_clr |=> st_ff.iflag;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("input flag set lost to read");

	property p_read_keeps_brk;
		@(posedge core_clk) disable iff (srst)
		rd_clr && st_ff.brk && !brk_clr
			&& !(rx_done && rx_full_ff && !data_rd)
			|=> st_ff.brk && !st_ff.lost;
	endproperty
	a_read_keeps_brk: assert property (p_read_keeps_brk)
		else $error("read disturbed break or kept lost");

	property p_lost;
		@(posedge core_clk) disable iff (srst)
		rx_done && rx_full_ff && !data_rd |=> st_ff.lost;
	endproperty
	a_lost: assert property (p_lost)
		else $error("character lost not flagged");

	property p_rx_off;
		@(posedge core_clk) disable iff (srst)
		!rx_en_ff |=> rx_state_ff == RX_IDLE && !rx_full_ff;
	endproperty
	a_rx_off: assert property (p_rx_off)
		else $error("receiver active while disabled");

endmodule // atli_line_iface

// File: sim/atli_term_model.sv
// Behavioural terminal on the far end of the serial line
`timescale 1ns/1ps
module atli_term_model (
	input  wire logic core_clk,
	input  wire logic txd_pin,
	output logic      rxd_pin,
	output logic      carrier_pin
);
	initial begin
		rxd_pin = 1'b1;
		carrier_pin = 1'b1;
	end

	task automatic set_carrier(input logic v);
		@(negedge core_clk);
		carrier_pin = v;
	endtask

	// A bad stop is cut just past mid-bit so it never looks like a start
	task automatic send_char(input logic [7:0] ch, input logic stop_ok,
		input int bc);
		logic [9:0] fr;
		fr = {stop_ok, ch, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge core_clk);
			rxd_pin = fr[i];
			repeat ((i == 9 && !stop_ok) ? bc / 2 + 20 : bc - 1)
				@(negedge core_clk);
		end
		@(negedge core_clk);
		rxd_pin = 1'b1;
		repeat (bc) @(negedge core_clk);
	endtask

	// Samples mid-bit; returns at mid stop bit
	task automatic get_char(input int bc, output logic [7:0] ch,
		output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		ch = 8'h00;
		while (txd_pin !== 1'b0 && n < 40 * bc) begin
			@(negedge core_clk);
			n++;
		end
		if (n < 40 * bc) begin
			repeat (bc / 2) @(negedge core_clk);
			ok = (txd_pin === 1'b0);
			for (int i = 0; i < 8; i++) begin
				repeat (bc) @(negedge core_clk);
				ch[i] = txd_pin;
			end
			repeat (bc) @(negedge core_clk);
			ok = ok && (txd_pin === 1'b1);
		end
	endtask
endmodule // atli_term_model

// File: sim/tb_atli_line_iface.sv
// Self-checking bench for the async terminal line interface
`timescale 1ns/1ps
module tb_atli_line_iface;
	// Slow core rate keeps serial frames short in simulation
	localparam int unsigned CORE_HZ = 1_600_000;
	localparam int FAST  = 16 * (CORE_HZ / (16 * 9600));
	localparam int SLOW  = 16 * (CORE_HZ / (16 * 4800));
	localparam int DISC  = 700 / 5;
	localparam int LIMIT = 100_000;

	logic        core_clk;
	logic        srst;
	logic        power_on_preset_pulse;
	logic        clear_control_instruction;
	logic        output_word_to_card;
	logic [15:0] out_word;
	logic        load_word_from_card;
	logic        rd_sel_data;
	logic        rxd_pin;
	logic        carrier_pin;
	logic        modem_pin;
	logic        out_ready;
	logic [15:0] rd_word;
	logic        card_flag;
	logic        txd_pin;
	logic        term_ready_pin;
	logic [15:0] junk;
	int          error_cnt;
	int          checks;
	int          cyc;

	atli_line_iface #(.core_hz(CORE_HZ)) i_dut (
		.core_clk                 (core_clk),
		.srst                     (srst),
		.power_on_preset_pulse    (power_on_preset_pulse),
		.clear_control_instruction(clear_control_instruction),
		.output_word_to_card      (output_word_to_card),
		.out_word                 (out_word),
		.load_word_from_card      (load_word_from_card),
		.rd_sel_data              (rd_sel_data),
		.rxd_pin                  (rxd_pin),
		.carrier_pin              (carrier_pin),
		.modem_pin                (modem_pin),
		.out_ready                (out_ready),
		.rd_word                  (rd_word),
		.card_flag                (card_flag),
		.txd_pin                  (txd_pin),
		.term_ready_pin           (term_ready_pin)
	);

	atli_term_model i_term (
		.core_clk   (core_clk),
		.txd_pin    (txd_pin),
		.rxd_pin    (rxd_pin),
		.carrier_pin(carrier_pin)
	);

	always #2.5 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk1(input string what, input logic e, input logic g);
		chk(what, {15'h0, e}, {15'h0, g});
	endtask

	task automatic wr(input logic [15:0] w);
		@(negedge core_clk);
		output_word_to_card = 1'b1;
		out_word = w;
		@(negedge core_clk);
		output_word_to_card = 1'b0;
	endtask

	task automatic rd(input logic sel, output logic [15:0] w);
		@(negedge core_clk);
		load_word_from_card = 1'b1;
		rd_sel_data = sel;
		@(negedge core_clk);
		load_word_from_card = 1'b0;
		@(negedge core_clk);
		w = rd_word;
	endtask

	task automatic st(input logic [15:0] e);
		logic [15:0] w;
		rd(1'b0, w);
		chk("status", e, w);
	endtask

	task automatic dat(input logic [7:0] e);
		logic [15:0] w;
		rd(1'b1, w);
		chk("rx data", {8'h00, e}, w);
	endtask

	task automatic rx_exp(input logic [7:0] e, input int bc);
		logic [7:0] ch;
		logic       ok;
		i_term.get_char(bc, ch, ok);
		chk("txd char", {8'h00, e}, {8'h00, ch});
		chk1("txd framing", 1'b1, ok);
	endtask

	task automatic tx(input logic [15:0] w, input logic [7:0] e,
		input int bc);
		wr(w);
		rx_exp(e, bc);
	endtask

	task automatic snd(input logic [7:0] ch, input logic ok, input int bc);
		i_term.send_char(ch, ok, bc);
		repeat (20) @(negedge core_clk);
	endtask

	task automatic t_reset();
		chk1("out_ready", 1'b1, out_ready);
		chk1("txd idle", 1'b1, txd_pin);
		chk1("term ready", 1'b1, term_ready_pin);
		st(16'h0000);
	endtask

	task automatic t_flags();
		wr(16'h8C00);
		repeat (2) @(negedge core_clk);
		chk1("card_flag", 1'b1, card_flag);
		st(16'h0C00);
		st(16'h0000);
	endtask

	task automatic t_tx();
		tx(16'h6241, 8'h41, FAST);
		st(16'h0400);
		wr(16'h01A0);
		tx(16'h0003, 8'h03, FAST);
		tx(16'h0007, 8'h87, FAST);
		wr(16'h0180);
		tx(16'h0007, 8'h07, FAST);
		tx(16'h0003, 8'h83, FAST);
		wr(16'h0100);
		tx(16'h0007, 8'h07, FAST);
	endtask

	task automatic t_wide();
		wr(16'h9000);
		rd(1'b0, junk);
		wr(16'h4142);
		rx_exp(8'h41, FAST);
		rx_exp(8'h42, FAST);
		st(16'h0400);
		@(negedge core_clk);
		clear_control_instruction = 1'b1;
		@(negedge core_clk);
		clear_control_instruction = 1'b0;
		tx(16'h0043, 8'h43, FAST);
		wr(16'h9000);
		@(negedge core_clk);
		power_on_preset_pulse = 1'b1;
		@(negedge core_clk);
		power_on_preset_pulse = 1'b0;
		tx(16'h0044, 8'h44, FAST);
	endtask

	task automatic t_disc();
		int n;
		n = 0;
		wr(16'h8200);
		while (term_ready_pin === 1'b1 && n < 5) begin
			@(negedge core_clk);
			n++;
		end
		n = 0;
		while (term_ready_pin === 1'b0 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		chk("disconnect length", 16'(DISC), 16'(n));
	endtask

	task automatic t_rx();
		rd(1'b0, junk);
		snd(8'h55, 1'b1, FAST);
		st(16'h0800);
		dat(8'h55);
		snd(8'h11, 1'b1, FAST);
		snd(8'h22, 1'b1, FAST);
		st(16'h0900);
		rd(1'b1, junk);
		snd(8'h00, 1'b0, FAST);
		st(16'h0A00);
		rd(1'b1, junk);
		st(16'h0200);
		snd(8'h33, 1'b1, FAST);
		st(16'h0800);
		dat(8'h33);
	endtask

	task automatic t_carrier();
		modem_pin = 1'b1;
		i_term.set_carrier(1'b0);
		repeat (6) @(negedge core_clk);
		st(16'h0A00);
		st(16'h0200);
		i_term.set_carrier(1'b1);
		repeat (6) @(negedge core_clk);
		st(16'h0800);
		modem_pin = 1'b0;
	endtask

	task automatic t_rxcfg();
		wr(16'h0160);
		snd(8'h01, 1'b1, FAST);
		dat(8'h81);
		snd(8'h03, 1'b1, FAST);
		dat(8'h03);
		wr(16'h0140);
		snd(8'h01, 1'b1, FAST);
		dat(8'h01);
		snd(8'h03, 1'b1, FAST);
		dat(8'h83);
		wr(16'h0100);
		wr(16'hC000);
		snd(8'h66, 1'b1, FAST);
		st(16'h0000);
		wr(16'hA000);
		snd(8'h67, 1'b1, FAST);
		dat(8'h67);
	endtask

	task automatic t_speed();
		wr(16'h0118);
		tx(16'h0021, 8'h21, SLOW);
		wr(16'h0110);
		tx(16'h0022, 8'h22, SLOW);
		wr(16'h0108);
		snd(8'h5A, 1'b1, SLOW);
		dat(8'h5A);
		wr(16'h0100);
		snd(8'h5B, 1'b1, SLOW);
		dat(8'h5B);
		wr(16'h0119);
		wr(16'h0109);
	endtask

	// Fill until the buffer refuses, then drain and check order
	task automatic t_buf();
		int n;
		n = 0;
		while (out_ready === 1'b1 && n < 8) begin
			wr(16'h0070 + 16'(n));
			@(negedge core_clk);
			n++;
		end
		chk1("out_ready full", 1'b0, out_ready);
		chk1("enough accepted", 1'b1, n >= 3);
		for (int i = 0; i < n; i++)
			rx_exp(8'h70 + 8'(i), FAST);
		chk1("out_ready drained", 1'b1, out_ready);
	endtask

	initial begin
		core_clk = 1'b0;
		srst = 1'b1;
		power_on_preset_pulse = 1'b0;
		clear_control_instruction = 1'b0;
		output_word_to_card = 1'b0;
		out_word = 16'h0000;
		load_word_from_card = 1'b0;
		rd_sel_data = 1'b0;
		modem_pin = 1'b0;
		repeat (10) @(negedge core_clk);
		srst = 1'b0;
		repeat (410) @(negedge core_clk);
		t_reset();
		t_flags();
		t_tx();
		t_wide();
		t_disc();
		t_rx();
		t_carrier();
		t_rxcfg();
		t_speed();
		t_buf();
		wrap_up();
	end
endmodule // tb_atli_line_iface
